// ==== rtl/brd_branch_resolve.v ====
`timescale 1ns/1ps
`include "brd_regs.vh"

module brd_branch_resolve (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_stall,
  input wire i_fetch_valid,
  input wire [31:0] i_fetch_insn,
  input wire [63:0] i_fetch_pc,
  input wire [63:0] i_fetch_rs_val,
  input wire [63:0] i_fetch_rt_val,
  output reg o_exec_redirect,
  output reg [63:0] o_exec_target,
  output reg o_exec_annul_slot,
  output reg o_exec_slot_pending,
  output reg o_exec_link_we,
  output reg [4:0] o_exec_link_reg,
  output reg [63:0] o_exec_link_data
);
  // ***************************************
  // Compare selector codes shared with the evaluator
  // ***************************************
  localparam [2:0] SEL_SAME = 3'h0;
  localparam [2:0] SEL_DIFFER = 3'h1;
  localparam [2:0] SEL_NONPOS = 3'h2;
  localparam [2:0] SEL_POS = 3'h3;
  localparam [2:0] SEL_NEG = 3'h4;
  localparam [2:0] SEL_NONNEG = 3'h5;
  localparam [2:0] SEL_NONE = 3'h7;

  // ***************************************
  // Register-fetch stage decode
  // ***************************************
  wire [5:0] op = i_fetch_insn[`BRD_OP_HI:`BRD_OP_LO];
  wire [4:0] sub = i_fetch_insn[`BRD_RT_HI:`BRD_RT_LO];
  reg is_branch;
  reg is_jump;
  reg likely;
  reg link;
  reg [2:0] sel;

  // Register-immediate group: bit 4 of the sub code asks for a link
  reg ri_branch;
  reg ri_likely;
  reg ri_link;
  reg [2:0] ri_sel;
  always @* begin
    ri_branch = 1'b1;
    ri_likely = 1'b0;
    ri_link = 1'b0;
    ri_sel = SEL_NONE;
    case (sub)
      `BRD_RI_NEG: begin
        ri_sel = SEL_NEG;
        ri_likely = 1'b0;
        ri_link = 1'b0;
      end
      `BRD_RI_NONNEG: begin
        ri_sel = SEL_NONNEG;
        ri_likely = 1'b0;
        ri_link = 1'b0;
      end
      `BRD_RI_NEG_L: begin
        ri_sel = SEL_NEG;
        ri_likely = 1'b1;
        ri_link = 1'b0;
      end
      `BRD_RI_NONNEG_L: begin
        ri_sel = SEL_NONNEG;
        ri_likely = 1'b1;
        ri_link = 1'b0;
      end
      `BRD_RI_NEG_LINK: begin
        ri_sel = SEL_NEG;
        ri_likely = 1'b0;
        ri_link = 1'b1;
      end
      `BRD_RI_NONNEG_LINK: begin
        ri_sel = SEL_NONNEG;
        ri_likely = 1'b0;
        ri_link = 1'b1;
      end
      `BRD_RI_NEG_LINK_L: begin
        ri_sel = SEL_NEG;
        ri_link = 1'b1;
        ri_likely = 1'b1;
      end
      `BRD_RI_NONNEG_LINK_L: begin
        ri_sel = SEL_NONNEG;
        ri_link = 1'b1;
        ri_likely = 1'b1;
      end
      default: begin
        ri_branch = 1'b0;
        ri_sel = SEL_NONE;
        ri_likely = 1'b0;
        ri_link = 1'b0;
      end
    endcase
  end

  // Primary opcode decode; every item names every field so none can latch
  always @* begin
    is_branch = 1'b1;
    is_jump = 1'b0;
    likely = 1'b0;
    link = 1'b0;
    sel = SEL_NONE;
    case (op)
      `BRD_OP_SAME: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_SAME;
      end
      `BRD_OP_DIFFER: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_DIFFER;
      end
      `BRD_OP_NONPOS: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_NONPOS;
      end
      `BRD_OP_POS: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_POS;
      end
      `BRD_OP_SAME_L: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        link = 1'b0;
        sel = SEL_SAME;
        likely = 1'b1;
      end
      `BRD_OP_DIFFER_L: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        link = 1'b0;
        sel = SEL_DIFFER;
        likely = 1'b1;
      end
      `BRD_OP_NONPOS_L: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        link = 1'b0;
        sel = SEL_NONPOS;
        likely = 1'b1;
      end
      `BRD_OP_POS_L: begin
        is_branch = 1'b1;
        is_jump = 1'b0;
        link = 1'b0;
        sel = SEL_POS;
        likely = 1'b1;
      end
      `BRD_OP_J, `BRD_OP_JAL: begin
        // Jumps only open a slot here; their target is formed elsewhere
        is_branch = 1'b0;
        is_jump = 1'b1;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_NONE;
      end
      `BRD_OP_RI_GROUP: begin
        is_branch = ri_branch;
        is_jump = 1'b0;
        likely = ri_likely;
        link = ri_link;
        sel = ri_sel;
      end
      default: begin
        is_branch = 1'b0;
        is_jump = 1'b0;
        likely = 1'b0;
        link = 1'b0;
        sel = SEL_NONE;
      end
    endcase
  end

  // ***************************************
  // Condition evaluation
  // ***************************************
  wire cond_true;
  brd_cond i_brd_cond (
    .i_rs(i_fetch_rs_val),
    .i_rt(i_fetch_rt_val),
    .i_sel(sel),
    .o_true(cond_true)
  );

  // ***************************************
  // Target and link arithmetic, started in register fetch
  // ***************************************
  // Delay slot sits one word after the branch
  wire [63:0] slot_pc = i_fetch_pc + `BRD_INSN_BYTES;
  wire [15:0] ofs_field = i_fetch_insn[`BRD_OFS_HI:0];
  wire [47:0] ofs_sign = {48{ofs_field[15]}};
  wire [63:0] ofs_wide = {ofs_sign, ofs_field};
  wire [63:0] ofs_ext = ofs_wide << `BRD_OFS_SHIFT;
  wire [63:0] target_sum = slot_pc + ofs_ext;
  // Return point is the word after the delay slot
  wire [63:0] link_sum = slot_pc + `BRD_INSN_BYTES;

  // ***************************************
  // Acceptance and next values
  // ***************************************
  // The instruction in an open slot is never decoded as a branch: a second
  // redirect there would lose the slot of the first
  wire take = i_fetch_valid & ~i_stall & ~o_exec_slot_pending;
  wire take_branch = take & is_branch;
  wire take_jump = take & is_jump;
  wire pending_nxt = take_branch | take_jump;
  wire redirect_nxt = take_branch & cond_true;
  // Only a failed likely branch kills its slot; all others run it
  wire annul_nxt = take_branch & likely & ~cond_true;
  // Link written regardless of the outcome, annulled likely forms too
  wire link_we_nxt = take_branch & link;

  // ***************************************
  // Execute stage registers
  // ***************************************
  // Compare and sum settle across late register fetch and early execute;
  // every output holds while the pipeline is frozen
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_slot_pending <= 1'b0;
    end else if (!i_stall) begin
      o_exec_slot_pending <= pending_nxt;
    end else begin
      o_exec_slot_pending <= o_exec_slot_pending;
    end
  end

  // Target fetch is issued while the branch sits in execute
  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_redirect <= 1'b0;
    end else if (!i_stall) begin
      o_exec_redirect <= redirect_nxt;
    end else begin
      o_exec_redirect <= o_exec_redirect;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_target <= 64'h0000000000000000;
    end else if (!i_stall) begin
      o_exec_target <= target_sum;
    end else begin
      o_exec_target <= o_exec_target;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_annul_slot <= 1'b0;
    end else if (!i_stall) begin
      o_exec_annul_slot <= annul_nxt;
    end else begin
      o_exec_annul_slot <= o_exec_annul_slot;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_link_we <= 1'b0;
    end else if (!i_stall) begin
      o_exec_link_we <= link_we_nxt;
    end else begin
      o_exec_link_we <= o_exec_link_we;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_link_reg <= 5'h00;
    end else if (!i_stall) begin
      o_exec_link_reg <= `BRD_LINK_REG;
    end else begin
      o_exec_link_reg <= o_exec_link_reg;
    end
  end

  always @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_exec_link_data <= 64'h0000000000000000;
    end else if (!i_stall) begin
      o_exec_link_data <= link_sum;
    end else begin
      o_exec_link_data <= o_exec_link_data;
    end
  end
endmodule

// ==== rtl/brd_regs.vh ====
`ifndef BRD_REGS_VH
`define BRD_REGS_VH
// Overview of operation
// - Target is delay-slot address plus sign-extended offset shifted left two.
// - Each branch is followed by exactly one delay-slot cycle.
// - Jumps also get exactly one delay-slot cycle, handled like branches.
// - Non-likely branches always execute their delay-slot instruction.
// - Likely branches with false condition annul the delay-slot instruction.
// - Target fetch is issued while the branch sits in execute stage.
// - Compare and target math span late register fetch and early execute.
// - Same-compare branches are taken when both registers are identical.
// - Differ-compare branches are taken when the registers differ.
// - Negative branches taken below zero; nonpositive branches also at zero.
// - Positive branches need strictly above zero; nonnegative also at zero.
// - Linking zero-compare branches write address after delay slot to r-link.
// - Same-likely branches when equal, otherwise discards the delay slot.

// Primary opcodes
`define BRD_OP_RI_GROUP 6'h01
`define BRD_OP_J 6'h02
`define BRD_OP_JAL 6'h03
`define BRD_OP_SAME 6'h04
`define BRD_OP_DIFFER 6'h05
`define BRD_OP_NONPOS 6'h06
`define BRD_OP_POS 6'h07
`define BRD_OP_SAME_L 6'h14
`define BRD_OP_DIFFER_L 6'h15
`define BRD_OP_NONPOS_L 6'h16
`define BRD_OP_POS_L 6'h17
// Register-immediate group sub codes
`define BRD_RI_NEG 5'h00
`define BRD_RI_NONNEG 5'h01
`define BRD_RI_NEG_L 5'h02
`define BRD_RI_NONNEG_L 5'h03
`define BRD_RI_NEG_LINK 5'h10
`define BRD_RI_NONNEG_LINK 5'h11
`define BRD_RI_NEG_LINK_L 5'h12
`define BRD_RI_NONNEG_LINK_L 5'h13
// Field positions, link register, instruction size and offset shift
`define BRD_OP_HI 31
`define BRD_OP_LO 26
`define BRD_RT_HI 20
`define BRD_RT_LO 16
`define BRD_OFS_HI 15
`define BRD_LINK_REG 5'h1F
`define BRD_INSN_BYTES 64'h0000000000000004
`define BRD_OFS_SHIFT 2
`endif

// ==== rtl/brd_cond.v ====
`timescale 1ns/1ps
// Condition evaluator; purely combinational
module brd_cond (
  input wire [63:0] i_rs,
  input wire [63:0] i_rt,
  input wire [2:0] i_sel,
  output reg o_true
);
  wire neg = i_rs[63];
  wire zero = (i_rs == 64'h0000000000000000);
  always @* begin
    case (i_sel)
      3'h0: o_true = (i_rs == i_rt);
      3'h1: o_true = (i_rs != i_rt);
      3'h2: o_true = neg | zero;
      3'h3: o_true = ~neg & ~zero;
      3'h4: o_true = neg;
      3'h5: o_true = ~neg;
      default: o_true = 1'b0;
    endcase
  end
endmodule

// ==== verif/brd_monitor.sv ====
`timescale 1ns/1ps
module brd_monitor (
  input wire i_clock,
  input wire i_rst_n,
  input wire i_stall,
  input wire i_fetch_valid,
  input wire o_exec_redirect,
  input wire o_exec_annul_slot,
  input wire o_exec_slot_pending,
  input wire o_exec_link_we,
  input wire [31:0] i_fetch_insn,
  input wire [63:0] i_fetch_pc,
  input wire [63:0] i_fetch_rs_val,
  input wire [63:0] i_fetch_rt_val,
  input wire [63:0] o_exec_target,
  input wire [63:0] o_exec_link_data,
  input wire [4:0] o_exec_link_reg
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  wire [5:0] op = i_fetch_insn[31:26];
  wire [4:0] sb = i_fetch_insn[20:16];
  wire sg = i_fetch_rs_val[63];
  wire ri = op == 6'h01 && sb[3:2] == 2'h0;
  wire bc = ri || op[5:2] == 4'h1 || op[5:2] == 4'h5;
  wire pn = bc || op[5:1] == 5'h01;
  wire c = bc && (ri ? sb[0] ^ sg :
    op[0] ^ (op[1] ? sg | ~|i_fetch_rs_val : i_fetch_rs_val == i_fetch_rt_val));
  wire an = bc && !c && (ri ? sb[1] : op[4]);
  wire lw = ri && sb[4];
  wire tk = i_fetch_valid && !i_stall && !o_exec_slot_pending;
  wire [63:0] la = i_fetch_pc + 64'h8;
  wire [63:0] tg = i_fetch_pc + 64'h4 + {{46{i_fetch_insn[15]}}, i_fetch_insn[15:0], 2'h0};
  sequence s_slot; o_exec_slot_pending && !i_stall; endsequence
  property p_tgt; tk && c |=> o_exec_target == $past(tg); endproperty
  a_tgt: assert property (p_tgt) else $error("tgt");
  property p_pnd; tk |=> o_exec_slot_pending == $past(pn); endproperty
  a_pnd: assert property (p_pnd) else $error("pnd");
  property p_one; s_slot |=> !o_exec_slot_pending && !o_exec_redirect; endproperty
  a_one: assert property (p_one) else $error("one");
  property p_red; tk |=> o_exec_redirect == $past(c); endproperty
  a_red: assert property (p_red) else $error("red");
  property p_anl; tk |=> o_exec_annul_slot == $past(an); endproperty
  a_anl: assert property (p_anl) else $error("anl");
  property p_lwe; tk |=> o_exec_link_we == $past(lw); endproperty
  a_lwe: assert property (p_lwe) else $error("lwe");
  property p_ldt;
    tk && lw |=> o_exec_link_reg == 5'h1F && o_exec_link_data == $past(la);
  endproperty
  a_ldt: assert property (p_ldt) else $error("ldt");
  property p_hld; i_stall |=> $stable(o_exec_target) && $stable(o_exec_redirect); endproperty
  a_hld: assert property (p_hld) else $error("hld");
endmodule
bind brd_branch_resolve brd_monitor i_mon (.*);

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic i_clock = 0, i_rst_n = 0, i_stall = 0, i_fetch_valid = 0, c, l;
  logic [31:0] i_fetch_insn = 0;
  logic [63:0] i_fetch_pc = 0, i_fetch_rs_val = 0, i_fetch_rt_val = 0, a;
  logic [5:0] op, k;
  wire o_exec_redirect, o_exec_annul_slot, o_exec_slot_pending, o_exec_link_we;
  wire [4:0] o_exec_link_reg;
  wire [63:0] o_exec_target, o_exec_link_data;
  int num_errors = 0, num_checks = 0;
  brd_branch_resolve i_brd_branch_resolve (.*);
  initial forever #25 i_clock = ~i_clock;
  task ck(string n, logic [131:0] e, s);
    num_checks++;
    if (s !== e) $display("unexpected %s exp %h got %h", n, e, s);
    if (s !== e) num_errors++;
  endtask
  task stop_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task go(logic [31:0] w, logic [63:0] b, bit s);
    longint sa;
    bit ri, bc;
    sa = a;
    op = w[31:26];
    ri = op == 1 && w[19:18] == 0;
    bc = ri || op inside {[4:7], [20:23]};
    c = bc && (ri ? (w[16] ? sa >= 0 : sa < 0) :
      op[1] ? (op[0] ? sa > 0 : sa <= 0) : op[0] ^ (a == b));
    l = ri && w[20];
    {i_fetch_insn, i_fetch_pc, i_fetch_rs_val, i_fetch_rt_val, i_fetch_valid} =
      {w, ({$urandom, $urandom} << 2), a, b, 1'b1};
    for (int j = 0; j <= s; j++) begin
      @(posedge i_clock);
      #5 i_stall = s && j == 0;
      ck("out", {c, bc && !c && (ri ? w[17] : op[4]), bc || op inside {2, 3}, l,
        c ? i_fetch_pc + 4 + {{46{w[15]}}, w[15:0], 2'h0} : 64'h0, l ? i_fetch_pc + 8 : 64'h0},
        {o_exec_redirect, o_exec_annul_slot, o_exec_slot_pending, o_exec_link_we,
        c ? o_exec_target : 64'h0, l ? o_exec_link_data : 64'h0});
    end
    // Same word again: after a branch or jump it sits in the slot; no word may redirect or open a slot here
    @(posedge i_clock);
    #5 ck("slot", 0, {o_exec_redirect, o_exec_slot_pending});
    $display("done %h", w);
  endtask
  initial begin
    void'($urandom(84));
    repeat (8) @(posedge i_clock);
    #5 i_rst_n = 1;
    @(posedge i_clock);
    #5;
    for (int i = 0; i < 96; i++) begin
      k = i / 3;
      a = i % 3 == 0 ? 64'h0 : {$urandom, $urandom};
      go(k < 24 ? {k, 26'($urandom)} : {6'h01, 5'($urandom), k[2], 2'h0, k[1:0], 16'($urandom)},
        i % 3 == 1 ? a : {$urandom, $urandom}, i % 3 == 2);
    end
    stop_test;
  end
  initial begin
    #50000;
    num_errors++;
    stop_test;
  end
endmodule
